/* hw/int_signal_pkg.sv */
/*
 * Package for the event interrupt signalling block: timing constants,
 * reset values, the carrier struct for status inputs and the mode and line state enums.
 * Assumes a 100 MHz system clock.
 */
package int_signal_pkg;

    // System clock rate in kHz.
    localparam int CLK_KHZ = 100000;

    // Pulse width, least gap and config filter time in microseconds.
    localparam int PULSE_WIDTH_US = 100;
    localparam int PULSE_GAP_US = 80;
    localparam int CFG_FILTER_US = 10;

    // Cycle counts derived from the times; the gap is a least time, rounded up.
    localparam int PULSE_WIDTH_CYC = (PULSE_WIDTH_US * CLK_KHZ) / 1000;
    localparam int PULSE_GAP_CYC = (PULSE_GAP_US * CLK_KHZ + 999) / 1000;
    localparam int CFG_FILTER_CYC = (CFG_FILTER_US * CLK_KHZ) / 1000;

    // Width of the timing counter.
    localparam int TIMER_W = 16;

    // Reset values.
    localparam logic GLOBAL_SEL_RESET = 1'b0;
    localparam logic CONFIG_LEVEL_RESET = 1'b0;

    // Operating modes as seen by this block.
    typedef enum logic [1:0] {
        MODE_INIT,
        MODE_NORMAL,
        MODE_STOP,
        MODE_OTHER
    } op_mode_type;

    // Latched status presented to the block; width is that of each register.
    typedef struct packed {
        logic [7:0] wake_latch_first;
        logic [7:0] wake_latch_second;
        logic [7:0] wake_enable_first;
        logic [7:0] wake_enable_second;
        logic [15:0] failure_flags;
        logic [15:0] failure_excluded;
    } status_in_type;

    // Pulse line states.
    typedef enum logic [1:0] {
        LINE_IDLE,
        LINE_PULSE,
        LINE_GAP
    } line_state_type;

endpackage : int_signal_pkg

/* hw/event_interrupt_signaling.sv */
/*
 * Interrupt pulse generator: turns enabled wake events (and, when global
 * select is set, non-excluded failures) into fixed low pulses on the
 * interrupt line, and samples the line as a configuration strap in init mode.
 * Assumes status flags are latched and cleared elsewhere by the serial port,
 * and that the line input comes from the pad, asynchronous to the clock.
 */
`timescale 1ns/1ns
`default_nettype none

// Operation
// - Pulse line low 100 us in normal/stop.
// - Keep line high at least 80 us.
// - Interrupts never change the operating mode.
// - Global select 0: enabled wake latches only.
// - Wake events need their source enabled; stop entry also counts wake latches that are not enabled.
// - Global select 1: failures also interrupt.
// - Wake level snapshot never interrupts.
// - Restart/fail-safe faults never interrupt.
// - Reset flag and state registers never interrupt.
// - Stop entry with wake bits set pulses.
// - Status update strobe at pulse falling edge.
// - Events held until host reads and clears.
// - Init mode samples line, no driving.
// - Config level filtered 10 us first.
// - All times counted from internal clock.
module event_interrupt_signaling
    import int_signal_pkg::*;
(
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    // Mode and configuration.
    input wire op_mode_type i_mode,
    input wire logic i_global_sel,
    input wire logic i_stop_entry,
    // Latched status.
    input wire status_in_type i_status,
    // Interrupt line pad.
    input wire logic i_int_line,
    output logic o_int_line,
    output logic o_int_line_oe,
    // Status update strobe and configuration result.
    output logic o_status_update,
    output logic o_config_level,
    output logic o_config_valid
);

    logic rst_meta_reg;
    logic rst_sync_reg;
    logic rstn;
    logic line_meta_reg;
    logic line_sync_reg;
    line_state_type state_reg, state_next;
    logic [TIMER_W-1:0] timer_reg, timer_next;
    logic pending_reg, pending_next;
    logic src_prev_reg, src_prev_next;
    logic out_reg, out_next;
    logic oe_reg, oe_next;
    logic upd_reg, upd_next;
    logic [TIMER_W-1:0] flt_cnt_reg, flt_cnt_next;
    logic cfg_reg, cfg_next;
    logic cfg_valid_reg, cfg_valid_next;
    logic wake_any;
    logic wake_left;
    logic fail_any;
    logic source;
    logic active_mode;

    // Reset release through two flip-flops.
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    assign rstn = rst_sync_reg;

    // Two-stage synchroniser for the pad level.
    always_ff @(posedge i_sys_clk or negedge rstn) begin
        if (!rstn) begin
            line_meta_reg <= 1'b1;
            line_sync_reg <= 1'b1;
        end else begin
            line_meta_reg <= i_int_line;
            line_sync_reg <= line_meta_reg;
        end
    end

    // Interrupt sources; the level snapshot, reset flag and state registers
    // are not inputs here at all, and fatal faults are masked out.
    assign wake_any = |((i_status.wake_latch_first & i_status.wake_enable_first) |
                         (i_status.wake_latch_second & i_status.wake_enable_second));
    assign wake_left = |{i_status.wake_latch_first, i_status.wake_latch_second};
    assign fail_any = |(i_status.failure_flags & ~i_status.failure_excluded);
    assign source = wake_any | (i_global_sel & fail_any);
    assign active_mode = (i_mode == MODE_NORMAL) || (i_mode == MODE_STOP);

    // Next state of the pulse line; the mode input is only read, never driven.
    always_comb begin
        state_next = state_reg;
        timer_next = timer_reg;
        pending_next = pending_reg;
        src_prev_next = source;
        out_next = out_reg;
        oe_next = active_mode;
        upd_next = 1'b0;
        // A new rising event, or stop entry with wake bits left, is kept.
        if ((source && !src_prev_reg) || (i_stop_entry && wake_left)) begin
            pending_next = 1'b1;
        end
        unique case (state_reg)
            LINE_IDLE: begin
                out_next = 1'b1;
                if (active_mode && (pending_next || source)) begin
                    state_next = LINE_PULSE;
                    timer_next = TIMER_W'(PULSE_WIDTH_CYC - 1);
                    pending_next = 1'b0;
                    out_next = 1'b0;
                    upd_next = 1'b1;
                end
            end
            LINE_PULSE: begin
                out_next = 1'b0;
                if (timer_reg == '0) begin
                    state_next = LINE_GAP;
                    timer_next = TIMER_W'(PULSE_GAP_CYC - 1);
                    out_next = 1'b1;
                end else begin
                    timer_next = timer_reg - 1'b1;
                end
            end
            LINE_GAP: begin
                out_next = 1'b1;
                if (timer_reg == '0) begin
                    state_next = LINE_IDLE;
                end else begin
                    timer_next = timer_reg - 1'b1;
                end
            end
            default: begin
                state_next = LINE_IDLE;
                out_next = 1'b1;
            end
        endcase
        if (!active_mode) begin
            state_next = LINE_IDLE;
            out_next = 1'b1;
            upd_next = 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= LINE_IDLE;
            timer_reg <= '0;
            pending_reg <= 1'b0;
            src_prev_reg <= 1'b0;
            out_reg <= 1'b1;
            oe_reg <= 1'b0;
            upd_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            timer_reg <= timer_next;
            pending_reg <= pending_next;
            src_prev_reg <= src_prev_next;
            out_reg <= out_next;
            oe_reg <= oe_next;
            upd_reg <= upd_next;
        end
    end

    // Configuration strap filter: the level must be stable for the filter time.
    always_comb begin
        flt_cnt_next = flt_cnt_reg;
        cfg_next = cfg_reg;
        cfg_valid_next = cfg_valid_reg;
        if (i_mode == MODE_INIT) begin
            if (line_sync_reg == cfg_reg) begin
                flt_cnt_next = '0;
                cfg_valid_next = 1'b1;
            end else if (flt_cnt_reg == TIMER_W'(CFG_FILTER_CYC - 1)) begin
                cfg_next = line_sync_reg;
                flt_cnt_next = '0;
                cfg_valid_next = 1'b1;
            end else begin
                flt_cnt_next = flt_cnt_reg + 1'b1;
                cfg_valid_next = 1'b0;
            end
        end else begin
            flt_cnt_next = '0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge rstn) begin
        if (!rstn) begin
            flt_cnt_reg <= '0;
            cfg_reg <= CONFIG_LEVEL_RESET;
            cfg_valid_reg <= 1'b0;
        end else begin
            flt_cnt_reg <= flt_cnt_next;
            cfg_reg <= cfg_next;
            cfg_valid_reg <= cfg_valid_next;
        end
    end

    assign o_int_line = out_reg;
    assign o_int_line_oe = oe_reg;
    assign o_status_update = upd_reg;
    assign o_config_level = cfg_reg;
    assign o_config_valid = cfg_valid_reg;

    // Counts cycles the line has stood low, and high up to a ceiling, for the
    // width and gap checks; the high count starts full so the first pulse passes.
    logic [TIMER_W-1:0] low_cnt_reg, low_cnt_next;
    logic [TIMER_W-1:0] high_cnt_reg, high_cnt_next;
    always_comb begin
        low_cnt_next = out_reg ? '0 : low_cnt_reg + 1'b1;
        high_cnt_next = high_cnt_reg;
        if (!out_reg) begin
            high_cnt_next = '0;
        end else if (high_cnt_reg != '1) begin
            high_cnt_next = high_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge rstn) begin
        if (!rstn) begin
            low_cnt_reg <= '0;
            high_cnt_reg <= '1;
        end else begin
            low_cnt_reg <= low_cnt_next;
            high_cnt_reg <= high_cnt_next;
        end
    end

    sequence pulse_start_s;
        $fell(out_reg);
    endsequence

    pulse_width_a: assert property (@(posedge i_sys_clk) disable iff (!rstn)
        $rose(out_reg) && active_mode |-> $past(low_cnt_reg) == TIMER_W'(PULSE_WIDTH_CYC - 1))
        else $error("Interrupt pulse width wrong.");
    pulse_gap_a: assert property (@(posedge i_sys_clk) disable iff (!rstn)
        pulse_start_s |-> high_cnt_reg >= TIMER_W'(PULSE_GAP_CYC))
        else $error("Interrupt gap too short.");
    gap_state_a: assert property (@(posedge i_sys_clk) disable iff (!rstn)
        state_reg == LINE_GAP |-> out_reg)
        else $error("Line low during gap.");
    update_edge_a: assert property (@(posedge i_sys_clk) disable iff (!rstn)
        pulse_start_s |-> upd_reg)
        else $error("No status update at pulse start.");
    init_release_a: assert property (@(posedge i_sys_clk) disable iff (!rstn)
        i_mode == MODE_INIT |=> !oe_reg)
        else $error("Line driven in init mode.");
    stop_pulse_a: assert property (@(posedge i_sys_clk) disable iff (!rstn)
        i_stop_entry && wake_left && i_mode == MODE_STOP ##1 i_mode == MODE_STOP [*1]
        |-> pending_reg || state_reg != LINE_IDLE)
        else $error("Stop entry event lost.");
    fail_mask_a: assert property (@(posedge i_sys_clk) disable iff (!rstn)
        !i_global_sel && !wake_any && !pending_reg && state_reg == LINE_IDLE
        && !i_stop_entry |=> out_reg)
        else $error("Pulse without wake event.");
    pending_keep_a: assert property (@(posedge i_sys_clk) disable iff (!rstn)
        pending_reg && state_reg != LINE_IDLE && active_mode |=> pending_reg)
        else $error("Pending event dropped.");

endmodule : event_interrupt_signaling

`default_nettype wire

/* verification/host_mcu_model.sv */
/*
 * Host side of the interrupt line: holds the status latches that the
 * device presents, and reads and clears them after each interrupt.
 * Assumes the bench posts events as one-cycle pulses on i_event.
 */
`timescale 1ns/1ns
`default_nettype none
module host_mcu_model
    import int_signal_pkg::*;
#(
    parameter int HOST_DELAY = 50
)
(
    // Clock.
    input wire logic i_sys_clk,
    // Event pulses and enables from the bench.
    input wire status_in_type i_event,
    // Interrupt pad level.
    input wire logic i_pad,
    // Status seen by the device.
    output status_in_type o_status
);
    logic pad_d = 1'b0;
    int wait_cnt = -1;
    logic [31:0] held = 32'h0;

    // Latches events; a falling pad starts a delayed read that clears them.
    always @(posedge i_sys_clk) begin
        pad_d <= i_pad;
        if (pad_d && !i_pad) begin
            wait_cnt <= HOST_DELAY;
        end else if (wait_cnt >= 0) begin
            wait_cnt <= wait_cnt - 1;
        end
        // Events stay set until the host clears them; a fall during the wait restarts the delayed read.
        held <= (wait_cnt == 0 ? 32'h0 : held) |
            {i_event.wake_latch_first, i_event.wake_latch_second, i_event.failure_flags};
    end

    // Presents the held latches beside the bench's enables and masks.
    always_comb begin
        o_status = i_event;
        {o_status.wake_latch_first, o_status.wake_latch_second, o_status.failure_flags} = held;
    end
endmodule : host_mcu_model
`default_nettype wire

/* verification/event_interrupt_signaling_tb_top.sv */
/*
 * Self-checking bench for the interrupt pulse generator.
 * Assumes the host model holds the status latches; the pad is the
 * driven line while enabled, else the strap level.
 */
`timescale 1ns/1ns
`default_nettype none
module event_interrupt_signaling_tb_top;
    import int_signal_pkg::*;
    logic clk = 1'b0;
    logic rstn;
    op_mode_type mode;
    logic gsel, stop, strap, line, oe, upd, cfg, cfg_ok;
    wire logic pad;
    status_in_type ev, st;
    int error_cnt, checked, n, seed;
    logic [7:0] wb;
    logic [15:0] fb;

    // Clock of 100 MHz.
    always #5 clk = ~clk;
    // Pad level resolved from the driver enable and the strap pull.
    assign pad = oe ? line : strap;

    event_interrupt_signaling event_interrupt_signaling_i (.i_sys_clk(clk), .i_rstn(rstn),
        .i_mode(mode), .i_global_sel(gsel), .i_stop_entry(stop), .i_status(st),
        .i_int_line(pad), .o_int_line(line), .o_int_line_oe(oe), .o_status_update(upd),
        .o_config_level(cfg), .o_config_valid(cfg_ok));
    host_mcu_model host_mcu_model_i (.i_sys_clk(clk), .i_event(ev), .i_pad(pad), .o_status(st));

    // Prints the counts and the verdict, then ends the run.
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    // Compares one value and reports a mismatch.
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk

    // Waits, bounded, for the line to reach a level; n counts the cycles.
    task automatic wait_line(input logic lvl, input int lim);
        n = 0;
        while (line !== lvl && n < lim) begin
            @(negedge clk);
            n++;
        end
        chk("line_level", lvl, line);
        if (line !== lvl) complete_run();
    endtask : wait_line

    // Checks that the line stays high for a number of cycles.
    task automatic quiet(input int cyc);
        int lows;
        lows = 0;
        repeat (cyc) begin
            @(negedge clk);
            lows += (line !== 1'b1);
        end
        chk("quiet_low_cycles", 0, 16'(lows));
    endtask : quiet

    // Posts one-cycle event pulses, with an optional stop entry.
    task automatic post(input logic [7:0] w1, input logic [7:0] w2, input logic [15:0] f,
        input logic s);
        ev.wake_latch_first = w1;
        ev.wake_latch_second = w2;
        ev.failure_flags = f;
        stop = s;
        @(negedge clk);
        {ev.wake_latch_first, ev.wake_latch_second, ev.failure_flags, stop} = '0;
    endtask : post

    // Main sequence.
    initial begin
        {rstn, gsel, stop, strap, error_cnt, checked} = '0;
        mode = MODE_INIT;
        ev = '0;
        seed = $urandom(99783);
        repeat (6) @(negedge clk);
        chk("reset_line", 1, line);
        chk("reset_oe", 0, oe);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        strap = 1'b1;
        repeat (500) @(negedge clk);
        strap = 1'b0;
        repeat (1100) @(negedge clk);
        chk("cfg_after_glitch", 0, cfg);
        chk("oe_init", 0, oe);
        strap = 1'b1;
        repeat (900) @(negedge clk);
        chk("cfg_early", 0, cfg);
        repeat (200) @(negedge clk);
        chk("cfg_taken", 1, cfg);
        chk("cfg_valid", 1, cfg_ok);
        $display("test config done");
        mode = MODE_NORMAL;
        wb = 8'h01 << ($urandom % 8);
        fb = 16'h0001 << ($urandom % 16);
        ev.wake_enable_first = ~wb;
        post(wb, 8'h00, fb, 1'b0);
        quiet(40);
        ev.wake_enable_first = 8'hff;
        wait_line(1'b0, 10);
        chk("update_at_fall", 1, upd);
        chk("oe_normal", 1, oe);
        @(negedge clk);
        chk("update_once", 0, upd);
        repeat (4000) @(negedge clk);
        post(~wb, 8'h00, 16'h0000, 1'b0);
        wait_line(1'b1, 10010);
        chk("pulse_width", 16'(PULSE_WIDTH_CYC), 16'(n + 4002));
        wait_line(1'b0, 8010);
        chk("gap_min", 1, n >= PULSE_GAP_CYC);
        chk("gap_pending", 1, n <= PULSE_GAP_CYC + 3);
        wait_line(1'b1, 10010);
        quiet(8100);
        $display("test wake class done");
        gsel = 1'b1;
        ev.failure_excluded = 16'hffff;
        post(8'h00, 8'h00, 16'($urandom) | fb, 1'b0);
        quiet(50);
        ev.failure_excluded = ~fb;
        wait_line(1'b0, 10);
        wait_line(1'b1, 10010);
        quiet(8100);
        $display("test global class done");
        gsel = 1'b0;
        mode = MODE_STOP;
        post(8'h00, wb, 16'h0000, 1'b0);
        quiet(20);
        chk("oe_stop", 1, oe);
        post(8'h00, 8'h00, 16'h0000, 1'b1);
        wait_line(1'b0, 10);
        wait_line(1'b1, 10010);
        mode = MODE_OTHER;
        repeat (5) @(negedge clk);
        chk("oe_other", 0, oe);
        mode = MODE_INIT;
        repeat (5) @(negedge clk);
        chk("oe_back_init", 0, oe);
        $display("test stop entry done");
        complete_run();
    end
endmodule : event_interrupt_signaling_tb_top
`default_nettype wire
